// ### design/cmc_requester.sv
// requester end of the core memory bus: drives cycles ordered through registers
`timescale 1ns/1ps
`include "cmc_map.svh"
module cmc_requester (
    input  wire logic                    clk,
    input  wire logic                    resetn,
    // software port
    input  wire logic [3:0]              regAddr,
    input  wire logic [31:0]             regWdata,
    input  wire logic                    regWrite,
    input  wire logic                    regRead,
    output logic      [31:0]             regRdata,
    // memory bus, electrical levels (low = asserted, except dataLinesOe and parityOe, which enable when high)
    output logic                         requestN,
    output logic                         readSelectN,
    output logic                         writeSelectN,
    output logic                         dataTakenN,
    output logic                         releaseLevelN,
    input  wire logic                    addrAckN,
    input  wire logic                    busOccupiedN,
    input  wire logic                    readValidN,
    input  wire logic                    releaseAckN,
    input  wire logic [`CMC_WORD_W-1:0]  dataLinesIn,
    output logic      [`CMC_WORD_W-1:0]  dataLinesOut,
    output logic                         dataLinesOe,
    input  wire logic                    parityIn,
    output logic                         parityOut,
    output logic                         parityOe
);
    typedef enum logic [8:0] {
        S_IDLE   = 9'h001,
        S_ADDR   = 9'h002,
        S_REQ    = 9'h004,
        S_DROP   = 9'h008,
        S_WDATA  = 9'h010,
        S_RDWAIT = 9'h020,
        S_PAUSE  = 9'h040,
        S_REL    = 9'h080,
        S_END    = 9'h100
    } cmc_state_type;

    cmc_state_type          state_q, state_d;
    cmc_pkg::cmc_mode_type  mode_q, mode_d;
    cmc_pkg::cmc_ctl_type   ctl_q, ctl_d;
    cmc_pkg::cmc_sts_type   sts;
    logic [`CMC_ADDR_W-1:0] addr_q, addr_d;
    logic [`CMC_WORD_W-1:0] wdata_q, wdata_d;
    logic [`CMC_WORD_W-1:0] rdata_q, rdata_d;
    logic [`CMC_WORD_W-1:0] drive_q, drive_d;
    logic                   driveOe_q, driveOe_d;
    logic                   wpar_q, wpar_d;
    logic                   rpar_q, rpar_d;
    logic                   done_q, done_d;
    logic                   pause_q, pause_d;
    logic                   tout_q, tout_d;
    logic                   modWr_q, modWr_d;
    logic [15:0]            wait_q, wait_d;
    logic [31:0]            rd_q, rd_d;
    logic                   settleStart;
    logic                   settleDone;

    // translate pin levels to asserted sense
    assign sts.addrAck     = !addrAckN;
    assign sts.busOccupied = !busOccupiedN;
    assign sts.readValid   = !readValidN;
    assign sts.releaseAck  = !releaseAckN;

    function automatic logic selectsRead(input cmc_pkg::cmc_mode_type m);
        return (m == cmc_pkg::CMC_RESTORE) || (m == cmc_pkg::CMC_RPW);
    endfunction

    cmc_settle u_settle (
        .clk    (clk),
        .resetn (resetn),
        .start  (settleStart),
        .done   (settleDone)
    );

    logic startCmd;
    assign startCmd = regWrite && (regAddr == `CMC_REG_CTRL) && regWdata[`CMC_CTRL_START];

    always_comb begin
        state_d     = state_q;
        mode_d      = mode_q;
        ctl_d       = ctl_q;
        addr_d      = addr_q;
        wdata_d     = wdata_q;
        rdata_d     = rdata_q;
        drive_d     = drive_q;
        driveOe_d   = driveOe_q;
        wpar_d      = wpar_q;
        rpar_d      = rpar_q;
        done_d      = done_q;
        pause_d     = pause_q;
        tout_d      = tout_q;
        modWr_d     = modWr_q;
        wait_d      = (state_q == S_IDLE) ? 16'h0000 : wait_q + 16'h0001;
        settleStart = 1'b0;
        if (regWrite && regAddr == `CMC_REG_ADDR) begin
            addr_d = regWdata[`CMC_ADDR_W-1:0];
        end
        if (regWrite && regAddr == `CMC_REG_WDATA) begin
            wdata_d = regWdata[`CMC_WORD_W-1:0];
            wpar_d  = regWdata[`CMC_WORD_W];
        end
        if (regWrite && regAddr == `CMC_REG_CTRL && regWdata[`CMC_CTRL_MODWR]) begin
            modWr_d = 1'b1;
        end
        unique case (state_q)
            S_IDLE: begin
                if (startCmd && regWdata[`CMC_CTRL_MODE_HI:`CMC_CTRL_MODE_LO] != 2'h0) begin
                    mode_d    = cmc_pkg::cmc_mode_type'(
                        regWdata[`CMC_CTRL_MODE_HI:`CMC_CTRL_MODE_LO]);
                    done_d    = 1'b0;
                    pause_d   = 1'b0;
                    tout_d    = 1'b0;
                    modWr_d   = 1'b0;
                    state_d   = S_ADDR;
                end
            end
            S_ADDR: begin
                // wait for the bus to be free, then put address and selects
                if (!sts.busOccupied) begin
                    drive_d           = {1'b0, addr_q};
                    driveOe_d         = 1'b1;
                    ctl_d.readSelect  = mode_q[0];
                    ctl_d.writeSelect = mode_q[1];
                    settleStart       = 1'b1;
                    state_d           = S_REQ;
                end
            end
            S_REQ: begin
                if (settleDone) begin
                    ctl_d.request = 1'b1;
                end
                if (ctl_q.request && sts.addrAck) begin
                    ctl_d.request = 1'b0;
                    driveOe_d     = 1'b0;
                    state_d       = S_DROP;
                end
            end
            S_DROP: begin
                if (!sts.addrAck) begin
                    if (mode_q == cmc_pkg::CMC_CLRWR) begin
                        drive_d     = wdata_q;
                        driveOe_d   = 1'b1;
                        settleStart = 1'b1;
                        state_d     = S_WDATA;
                    end else begin
                        state_d = S_RDWAIT;
                    end
                end
            end
            S_WDATA: begin
                if (settleDone) begin
                    ctl_d.releaseLevel = 1'b1;
                    state_d            = S_REL;
                end
            end
            S_RDWAIT: begin
                // sample only on the data-valid strobe
                if (sts.readValid) begin
                    // ground level reads as one, same sense as the write path
                    rdata_d         = ~dataLinesIn;
                    rpar_d          = !parityIn;
                    ctl_d.dataTaken = 1'b1;
                    if (selectsRead(mode_q) && mode_q != cmc_pkg::CMC_RPW) begin
                        ctl_d.releaseLevel = 1'b1;
                        state_d            = S_REL;
                    end else begin
                        pause_d = 1'b1;
                        state_d = S_PAUSE;
                    end
                end
            end
            S_PAUSE: begin
                if (modWr_q) begin
                    drive_d     = wdata_q;
                    driveOe_d   = 1'b1;
                    ctl_d.dataTaken = 1'b0;
                    // a ready write landing in this very cycle wins over the clear
                    modWr_d     = regWrite && (regAddr == `CMC_REG_CTRL)
                                  && regWdata[`CMC_CTRL_MODWR];
                    settleStart = 1'b1;
                end
                if (driveOe_q && settleDone) begin
                    ctl_d.releaseLevel = 1'b1;
                    pause_d            = 1'b0;
                    state_d            = S_REL;
                end
            end
            S_REL: begin
                if (sts.releaseAck) begin
                    ctl_d.releaseLevel = 1'b0;
                    ctl_d.dataTaken    = 1'b0;
                    state_d            = S_END;
                end
            end
            S_END: begin
                if (!sts.releaseAck) begin
                    driveOe_d         = 1'b0;
                    ctl_d.readSelect  = 1'b0;
                    ctl_d.writeSelect = 1'b0;
                    done_d            = 1'b1;
                    state_d           = S_IDLE;
                end
            end
            default: state_d = S_IDLE;
        endcase
        if (state_q != S_IDLE && state_q != S_PAUSE && wait_q == `CMC_TIMEOUT_CYC) begin
            ctl_d     = '0;
            driveOe_d = 1'b0;
            tout_d    = 1'b1;
            state_d   = S_IDLE;
        end
        rd_d = 32'h00000000;
        if (regRead) begin
            unique case (regAddr)
                `CMC_REG_ADDR:   rd_d = {15'h0000, addr_q};
                `CMC_REG_WDATA:  rd_d = {13'h0000, wpar_q, wdata_q};
                `CMC_REG_RDATA:  rd_d = {14'h0000, rdata_q};
                `CMC_REG_CTRL:   rd_d = {29'h00000000, mode_q, 1'b0};
                `CMC_REG_STATUS: rd_d = {27'h0000000, rpar_q, tout_q, pause_q, done_q,
                                         state_q != S_IDLE};
                default:         rd_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q   <= S_IDLE;
            mode_q    <= cmc_pkg::CMC_RESTORE;
            ctl_q     <= '0;
            addr_q    <= 17'h00000;
            wdata_q   <= `CMC_RESET_WORD;
            rdata_q   <= `CMC_RESET_WORD;
            drive_q   <= `CMC_RESET_WORD;
            driveOe_q <= 1'b0;
            wpar_q    <= 1'b0;
            rpar_q    <= 1'b0;
            done_q    <= 1'b0;
            pause_q   <= 1'b0;
            tout_q    <= 1'b0;
            modWr_q   <= 1'b0;
            wait_q    <= 16'h0000;
            rd_q      <= 32'h00000000;
        end else begin
            state_q   <= state_d;
            mode_q    <= mode_d;
            ctl_q     <= ctl_d;
            addr_q    <= addr_d;
            wdata_q   <= wdata_d;
            rdata_q   <= rdata_d;
            drive_q   <= drive_d;
            driveOe_q <= driveOe_d;
            wpar_q    <= wpar_d;
            rpar_q    <= rpar_d;
            done_q    <= done_d;
            pause_q   <= pause_d;
            tout_q    <= tout_d;
            modWr_q   <= modWr_d;
            wait_q    <= wait_d;
            rd_q      <= rd_d;
        end
    end

    // active-low pins except the two high-true output enables; data one drives ground
    assign requestN      = !ctl_q.request;
    assign readSelectN   = !ctl_q.readSelect;
    assign writeSelectN  = !ctl_q.writeSelect;
    assign dataTakenN    = !ctl_q.dataTaken;
    assign releaseLevelN = !ctl_q.releaseLevel;
    assign dataLinesOut  = ~drive_q;
    assign dataLinesOe   = driveOe_q;
    assign parityOut     = !wpar_q;
    assign parityOe      = driveOe_q && (state_q != S_REQ);
    assign regRdata      = rd_q;
endmodule // cmc_requester

// ### inc/cmc_map.svh
// memory bus requester offsets, fields, reset values and timing counts
`ifndef CMC_MAP_SVH
`define CMC_MAP_SVH

`define CMC_CLK_NS          4
`define CMC_SETTLE_NS       50
`define CMC_SETTLE_CYC      ((`CMC_SETTLE_NS + `CMC_CLK_NS - 1) / `CMC_CLK_NS)
`define CMC_TIMEOUT_CYC     16'hffff

`define CMC_REG_CTRL        4'h0
`define CMC_REG_ADDR        4'h1
`define CMC_REG_WDATA       4'h2
`define CMC_REG_RDATA       4'h3
`define CMC_REG_STATUS      4'h4

`define CMC_CTRL_START      0
`define CMC_CTRL_MODE_LO    1
`define CMC_CTRL_MODE_HI    2
`define CMC_CTRL_MODWR      3

`define CMC_ST_BUSY         0
`define CMC_ST_DONE         1
`define CMC_ST_PAUSE        2
`define CMC_ST_TIMEOUT      3
`define CMC_ST_RPAR         4

`define CMC_WORD_W          18
`define CMC_ADDR_W          17
`define CMC_RESET_WORD      18'h00000

`endif

// ### inc/cmc_pkg.sv
// types for the core memory bus requester
package cmc_pkg;
    typedef enum logic [1:0] {
        CMC_RESTORE = 2'h1,
        CMC_CLRWR   = 2'h2,
        CMC_RPW     = 2'h3
    } cmc_mode_type;

    typedef struct packed {
        logic        request;
        logic        readSelect;
        logic        writeSelect;
        logic        dataTaken;
        logic        releaseLevel;
    } cmc_ctl_type;

    typedef struct packed {
        logic        addrAck;
        logic        busOccupied;
        logic        readValid;
        logic        releaseAck;
    } cmc_sts_type;
endpackage

// ### design/cmc_settle.sv
// settling counter: reports done after a fixed number of cycles
`timescale 1ns/1ps
`include "cmc_map.svh"
module cmc_settle (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic start,
    output logic      done
);
    logic [7:0] count_q;
    logic [7:0] count_d;
    logic       run_q;
    logic       run_d;

    always_comb begin
        count_d = count_q;
        run_d   = run_q;
        if (start) begin
            count_d = 8'h00;
            run_d   = 1'b1;
        end else if (run_q) begin
            count_d = count_q + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            count_q <= 8'h00;
            run_q   <= 1'b0;
        end else begin
            count_q <= count_d;
            run_q   <= run_d;
        end
    end

    assign done = run_q && !start && (count_q >= 8'(`CMC_SETTLE_CYC - 1));
endmodule // cmc_settle

// ### verif/cmc_requester_properties.sv
// bus-side checks of the core memory requester
`timescale 1ns/1ps
`include "cmc_map.svh"
module cmc_requester_props (
    input wire logic                   clk,
    input wire logic                   resetn,
    input wire logic                   requestN,
    input wire logic                   readSelectN,
    input wire logic                   writeSelectN,
    input wire logic                   dataTakenN,
    input wire logic                   releaseLevelN,
    input wire logic                   addrAckN,
    input wire logic                   busOccupiedN,
    input wire logic                   readValidN,
    input wire logic                   releaseAckN,
    input wire logic [`CMC_WORD_W-1:0] dataLinesOut,
    input wire logic                   dataLinesOe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_req_drop; $fell(addrAckN) |-> ##[1:3] requestN; endproperty
    a_req_drop: assert property (p_req_drop) else $error("request kept after ack");
    property p_sel; !requestN |-> !(readSelectN && writeSelectN); endproperty
    a_sel: assert property (p_sel) else $error("request without mode");
    property p_addr; $fell(requestN) |-> dataLinesOe && $past(dataLinesOe, 12)
        && dataLinesOut == $past(dataLinesOut, 12); endproperty
    a_addr: assert property (p_addr) else $error("address not settled");
    property p_pair; $fell(releaseLevelN) && writeSelectN |-> $fell(dataTakenN); endproperty
    a_pair: assert property (p_pair) else $error("release without data taken");
    property p_pause; $fell(dataTakenN) && !writeSelectN |-> releaseLevelN; endproperty
    a_pause: assert property (p_pause) else $error("release during pause");
    property p_wset; $fell(releaseLevelN) && !writeSelectN |-> dataLinesOe
        && $past(dataLinesOe, 12) && dataLinesOut == $past(dataLinesOut, 12); endproperty
    a_wset: assert property (p_wset) else $error("write data not settled");
    property p_hold; !releaseLevelN && releaseAckN |=> !releaseLevelN; endproperty
    a_hold: assert property (p_hold) else $error("release dropped early");
    property p_drop; $fell(releaseAckN) |-> ##[1:3] releaseLevelN; endproperty
    a_drop: assert property (p_drop) else $error("release kept after ack");
    property p_take; $fell(dataTakenN) |-> !readValidN; endproperty
    a_take: assert property (p_take) else $error("data taken without valid");
    property p_cw; !writeSelectN && readSelectN |-> dataTakenN; endproperty
    a_cw: assert property (p_cw) else $error("data taken in clear write");
    property p_busy; (requestN && !busOccupiedN) [*2] |=> requestN; endproperty
    a_busy: assert property (p_busy) else $error("request while bus busy");
endmodule // cmc_requester_props

bind cmc_requester cmc_requester_props chk_u (.clk(clk), .resetn(resetn), .requestN(requestN),
    .readSelectN(readSelectN), .writeSelectN(writeSelectN), .dataTakenN(dataTakenN),
    .releaseLevelN(releaseLevelN), .addrAckN(addrAckN), .busOccupiedN(busOccupiedN),
    .readValidN(readValidN), .releaseAckN(releaseAckN), .dataLinesOut(dataLinesOut),
    .dataLinesOe(dataLinesOe));

// ### verif/cmc_bank_model.sv
// behavioural core memory bank on the far side of the bus
`timescale 1ns/1ps
module cmc_bank_model (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        slow,
    input  wire logic        extBusy,
    input  wire logic        requestN,
    input  wire logic        readSelectN,
    input  wire logic        writeSelectN,
    input  wire logic        dataTakenN,
    input  wire logic        releaseLevelN,
    input  wire logic [17:0] dataLinesOut,
    input  wire logic        dataLinesOe,
    input  wire logic        parityOut,
    input  wire logic        parityOe,
    output logic             addrAckN,
    output logic             busOccupiedN,
    output logic             readValidN,
    output logic             releaseAckN,
    output logic      [17:0] dataLinesIn,
    output logic             parityIn
);
    logic [18:0] mem [256];
    logic [18:0] wordQ;
    logic [18:0] lastQ;
    logic [7:0]  addrQ;
    logic        rdQ, wrQ, busEnQ, busyQ;
    // lines nobody drives toggle so a stale word never looks valid
    assign dataLinesIn = busEnQ ? ~wordQ[17:0] : dataLinesOe ? dataLinesOut : ~lastQ[17:0];
    assign parityIn = busEnQ ? ~wordQ[18] : parityOe ? parityOut : ~lastQ[18];
    assign busOccupiedN = busyQ & ~extBusy;
    always @(posedge clk) begin
        lastQ <= {parityIn, dataLinesIn};
        if (!dataTakenN) busEnQ <= 1'b0;
    end
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 19'h0;
        {addrAckN, readValidN, releaseAckN, busyQ, busEnQ} = 5'h1e;
        lastQ = 19'h0;
        forever begin
            @(posedge clk);
            if (!resetn || requestN || !busOccupiedN) continue;
            addrQ = ~dataLinesOut[7:0];
            rdQ = !readSelectN;
            wrQ = !writeSelectN;
            wordQ = 19'h0;
            addrAckN <= 1'b0;
            busyQ <= 1'b0;
            while (!requestN) @(posedge clk);
            addrAckN <= 1'b1;
            repeat (slow ? 38 : 3) @(posedge clk);
            if (rdQ) begin
                wordQ = mem[addrQ];
                busEnQ <= 1'b1;
                repeat (slow ? 25 : 2) @(posedge clk);
                readValidN <= 1'b0;
            end
            while (releaseLevelN) @(posedge clk);
            if (wrQ) wordQ = {~parityIn, ~dataLinesIn};
            mem[addrQ] = wordQ;
            releaseAckN <= 1'b0;
            readValidN <= 1'b1;
            while (!releaseLevelN) @(posedge clk);
            releaseAckN <= 1'b1;
            busyQ <= 1'b1;
        end
    end
endmodule // cmc_bank_model

// ### verif/cmc_requester_test.sv
// self-checking bench for the core memory requester
`timescale 1ns/1ps
`include "cmc_map.svh"
module cmc_requester_test;
    logic        clk, resetn, regWrite, regRead, slow, extBusy;
    logic [3:0]  regAddr;
    logic [31:0] regWdata, regRdata, st, seed;
    logic        requestN, readSelectN, writeSelectN, dataTakenN, releaseLevelN;
    logic        addrAckN, busOccupiedN, readValidN, releaseAckN;
    logic        dataLinesOe, parityIn, parityOut, parityOe;
    logic [17:0] dataLinesIn, dataLinesOut;
    logic [18:0] shadow [256];
    int          failCount, numChecks;
    cmc_requester dut_u (.clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .requestN(requestN),
        .readSelectN(readSelectN), .writeSelectN(writeSelectN), .dataTakenN(dataTakenN),
        .releaseLevelN(releaseLevelN), .addrAckN(addrAckN), .busOccupiedN(busOccupiedN),
        .readValidN(readValidN), .releaseAckN(releaseAckN), .dataLinesIn(dataLinesIn),
        .dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe), .parityIn(parityIn),
        .parityOut(parityOut), .parityOe(parityOe));
    cmc_bank_model bank_u (.clk(clk), .resetn(resetn), .slow(slow), .extBusy(extBusy),
        .requestN(requestN), .readSelectN(readSelectN), .writeSelectN(writeSelectN),
        .dataTakenN(dataTakenN), .releaseLevelN(releaseLevelN), .dataLinesOut(dataLinesOut),
        .dataLinesOe(dataLinesOe), .parityOut(parityOut), .parityOe(parityOe),
        .addrAckN(addrAckN), .busOccupiedN(busOccupiedN), .readValidN(readValidN),
        .releaseAckN(releaseAckN), .dataLinesIn(dataLinesIn), .parityIn(parityIn));
    always #2 clk = ~clk;
    function automatic logic [31:0] nextRand(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            failCount++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stopTest();
        $display("checks %0d mismatches %0d", numChecks, failCount);
        if (failCount == 0 && numChecks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic regWr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic regRd(input logic [3:0] a);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1 st = regRdata;
    endtask
    task automatic waitFor(input int b, input logic v);
        int n;
        n = 0;
        regRd(`CMC_REG_STATUS);
        while (st[b] !== v && n < 3000) begin
            n++;
            regRd(`CMC_REG_STATUS);
        end
        check("status wait", {st[b]}, {v});
    endtask
    task automatic runCycle(input logic [1:0] mode, input logic [16:0] a, input logic [18:0] d,
                            input logic [18:0] m, input logic hold);
        logic [18:0] old;
        old = shadow[a[7:0]];
        extBusy <= hold;
        regWr(`CMC_REG_ADDR, {15'h0, a});
        regWr(`CMC_REG_WDATA, {13'h0, d});
        regWr(`CMC_REG_CTRL, {29'h0, mode, 1'b1});
        repeat (40) @(posedge clk);
        #1 check("held off", {requestN, hold & dataLinesOe}, 2'h2);
        extBusy <= 1'b0;
        if (mode == 2'h3) begin
            waitFor(`CMC_ST_PAUSE, 1'b1);
            regRd(`CMC_REG_RDATA);
            check("pause data", {st[17:0]}, {old[17:0]});
            regWr(`CMC_REG_WDATA, {13'h0, m});
            regWr(`CMC_REG_CTRL, {28'h1, mode, 1'b0});
            d = m;
        end
        waitFor(`CMC_ST_BUSY, 1'b0);
        check("status", {st[3:1]}, 3'h1);
        if (mode == 2'h1) begin
            check("read parity", {st[`CMC_ST_RPAR]}, {old[18]});
            regRd(`CMC_REG_RDATA);
            check("read data", {st[17:0]}, {old[17:0]});
        end else shadow[a[7:0]] = d;
        check("stored word", {bank_u.mem[a[7:0]]}, {shadow[a[7:0]]});
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        failCount++;
        $display("watchdog expired");
        stopTest();
    end
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        {regWrite, regRead, slow, extBusy} = 4'h0;
        regAddr = 4'h0;
        regWdata = 32'h0;
        seed = 32'hf8ec;
        for (int i = 0; i < 256; i++) shadow[i] = 19'h0;
        repeat (20) @(posedge clk);
        #1 check("idle pins", {requestN, readSelectN, writeSelectN, dataTakenN, releaseLevelN,
            dataLinesOe, parityOe}, 7'h7c);
        @(posedge clk);
        resetn <= 1'b1;
        regRd(4'hf);
        check("unmapped", st, 32'h0);
        // start with no mode selected must leave the sequencer idle
        regWr(`CMC_REG_CTRL, 32'h00000001);
        regRd(`CMC_REG_STATUS);
        check("mode zero start", {st[0]}, 32'h0);
        runCycle(2'h2, 17'h1ab05, 19'h5a5a5, 19'h0, 1'b1);
        runCycle(2'h1, 17'h1ab05, 19'h0, 19'h0, 1'b0);
        slow <= 1'b1;
        runCycle(2'h3, 17'h1ab05, 19'h0, 19'h7ffff, 1'b0);
        for (int k = 0; k < 14; k++) begin
            seed = nextRand(seed);
            slow <= seed[20];
            runCycle(2'(1 + seed[31:8] % 3), seed[16:0], seed[28:10], ~seed[18:0], 1'b0);
        end
        stopTest();
    end
endmodule // cmc_requester_test
